// [board_supervisor_model.sv]
// Board reset supervisor, strap drivers and pin pull-ups
`timescale 1ns/1ps
module board_supervisor_model (
  // Clock
  input  wire logic               i_clk_sys,
  // Device pin enables and board pulls
  input  wire logic               i_hard_oe,
  input  wire logic               i_soft_oe,
  input  wire logic               i_ext_hard,
  input  wire logic               i_ext_soft,
  // Board-side levels
  output logic                    o_por_n,
  output logic                    o_hard_n,
  output logic                    o_soft_n,
  output rst_seq_pkg::strap_t     o_straps
);
  // Pull-ups: low only while some party pulls
  assign o_hard_n = i_hard_oe & !i_ext_hard;
  assign o_soft_n = i_soft_oe & !i_ext_soft;
  initial begin
    o_por_n = 1'b0;
    o_straps = '0;
  end
  task automatic power_on(input rst_seq_pkg::strap_t s);
    @(posedge i_clk_sys);
    o_por_n <= 1'b0;
    o_straps <= s;
    repeat (16) @(posedge i_clk_sys);
    o_por_n <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    // Straps released: show a different pattern
    o_straps <= ~s;
  endtask
endmodule

// [reset_source_sequencer.sv]
// Reset source sequencer with AXI4-Lite register slave
//
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "rst_seq_consts.svh"
module reset_source_sequencer #(
  parameter int unsigned POR_DLY_CYC = `RS_POR_DLY_CYC,
  parameter int unsigned LOCK_CYC    = `RS_LOCK_CYC,
  parameter int unsigned HRST_CYC    = `RS_HRST_CYC,
  parameter int unsigned SRST_CYC    = `RS_SRST_CYC,
  parameter int unsigned RDF_W       = 2
) (
  // Clock and power-on reset
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_nrst,
  // Reset sources
  input  wire logic                  i_power_on_reset_n,
  input  wire logic                  i_wdog_expired,
  input  wire logic                  i_busmon_expired,
  input  wire logic                  i_jtag_reset_cmd,
  input  wire logic [RDF_W-1:0]      i_ref_division_factor,
  // Open-drain reset pins
  input  wire logic                  i_hard_reset_n,
  output logic                       o_hard_reset_n,
  output logic                       o_hard_reset_oe,
  input  wire logic                  i_soft_reset_n,
  output logic                       o_soft_reset_n,
  output logic                       o_soft_reset_oe,
  // Configuration straps and slave-port config write
  input  wire rst_seq_pkg::strap_t   i_straps,
  input  wire logic                  i_dsi_cfg_wr,
  input  wire logic [31:0]           i_dsi_cfg_data,
  // Reset actions
  output rst_seq_pkg::rst_act_t      o_rst_act,
  output logic                       o_pll_locked,
  output rst_seq_pkg::strap_t        o_straps,
  output logic [31:0]                o_cfg_word,
  // AXI4-Lite slave
  input  wire logic [7:0]            i_awaddr,
  input  wire logic                  i_awvalid,
  output logic                       o_awready,
  input  wire logic [31:0]           i_wdata,
  input  wire logic [3:0]            i_wstrb,
  input  wire logic                  i_wvalid,
  output logic                       o_wready,
  output logic [1:0]                 o_bresp,
  output logic                       o_bvalid,
  input  wire logic                  i_bready,
  input  wire logic [7:0]            i_araddr,
  input  wire logic                  i_arvalid,
  output logic                       o_arready,
  output logic [31:0]                o_rdata,
  output logic [1:0]                 o_rresp,
  output logic                       o_rvalid,
  input  wire logic                  i_rready
);
  localparam int unsigned CW = 24;

  rst_seq_pkg::phase_t   ph_r, ph_nxt;
  logic [CW-1:0]         cnt_r, cnt_nxt;
  logic                  por_seen_r, por_seen_nxt;
  logic                  hard_flow_r, hard_flow_nxt;
  logic                  hdrv_r, hdrv_nxt, sdrv_r, sdrv_nxt;
  rst_seq_pkg::src_t     stat_r, stat_nxt, pend_r, pend_nxt;
  rst_seq_pkg::strap_t   strap_r, strap_nxt;
  rst_seq_pkg::rst_act_t act_r, act_nxt;
  logic                  lock_r, lock_nxt;
  logic [31:0]           cfg_r, cfg_nxt;
  logic                  cfg_wr_r, cfg_wr_nxt;
  logic [2:0]            ctrl_r, ctrl_nxt;
  logic                  hpin_r, spin_r, hpin_prev_r, spin_prev_r;
  logic                  ext_hard, ext_soft, busy;
  logic [CW-1:0]         lock_lim;

  // Bus slave state
  logic                  aw_r, aw_nxt, w_r, w_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
  logic [7:0]            awa_r, awa_nxt;
  logic [31:0]           wd_r, wd_nxt, rd_r, rd_nxt;
  logic [1:0]            br_r, br_nxt, rr_r, rr_nxt;
  logic                  do_wr, cfg_wr_ok;

  // Any phase other than idle counts as busy; the read-back sees the wired level
  assign busy     = (ph_r != rst_seq_pkg::ST_IDLE);
  assign ext_hard = !hpin_r && hpin_prev_r && !hdrv_r;
  assign ext_soft = !spin_r && spin_prev_r && !sdrv_r && !busy;
  assign lock_lim = CW'(LOCK_CYC) * CW'(i_ref_division_factor == '0 ? 1 : i_ref_division_factor);
  assign do_wr    = aw_r && w_r && !bv_r;
  // bus config write only in slave mode during power-on or hard flow
  assign cfg_wr_ok = busy && hard_flow_r && ctrl_r[`RS_CTRL_CMODE_BIT];

  // Pin sampling for the read-back and edge detect
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      hpin_r      <= 1'b1;
      spin_r      <= 1'b1;
      hpin_prev_r <= 1'b1;
      spin_prev_r <= 1'b1;
    end else begin
      hpin_r      <= i_hard_reset_n;
      spin_r      <= i_soft_reset_n;
      hpin_prev_r <= hpin_r;
      spin_prev_r <= spin_r;
    end
  end

  always_comb begin
    ph_nxt        = ph_r;
    cnt_nxt       = cnt_r;
    por_seen_nxt  = por_seen_r;
    hard_flow_nxt = hard_flow_r;
    hdrv_nxt      = hdrv_r;
    sdrv_nxt      = sdrv_r;
    stat_nxt      = stat_r;
    pend_nxt      = pend_r;
    strap_nxt     = strap_r;
    lock_nxt      = lock_r;
    cfg_nxt       = cfg_r;
    cfg_wr_nxt    = cfg_wr_r;
    if (!i_power_on_reset_n) begin
      // Board keeps this low at least the minimum; we simply follow it
      ph_nxt        = rst_seq_pkg::ST_PORD;
      cnt_nxt       = '0;
      por_seen_nxt  = 1'b1;
      hard_flow_nxt = 1'b1;
      hdrv_nxt      = 1'b1;
      sdrv_nxt      = 1'b1;
      lock_nxt      = 1'b0;
      cfg_wr_nxt    = 1'b0;
      pend_nxt      = '{por: 1'b1, default: 1'b0};
      strap_nxt     = i_straps;
    end else begin
      if (por_seen_r) begin
        strap_nxt    = i_straps;
        por_seen_nxt = 1'b0;
      end
      case (ph_r)
        rst_seq_pkg::ST_IDLE: begin
          cnt_nxt = '0;
          if (ext_hard || i_wdog_expired || i_busmon_expired) begin
            ph_nxt        = rst_seq_pkg::ST_HREL;
            hard_flow_nxt = 1'b1;
            hdrv_nxt      = 1'b1;
            sdrv_nxt      = 1'b1;
            cfg_wr_nxt    = 1'b0;
            pend_nxt      = '{hard_pin: ext_hard, wdog: i_wdog_expired,
                              busmon: i_busmon_expired, default: 1'b0};
          end else if (ext_soft || i_jtag_reset_cmd) begin
            ph_nxt        = rst_seq_pkg::ST_SOFT;
            hard_flow_nxt = 1'b0;
            sdrv_nxt      = ext_soft || ctrl_r[`RS_CTRL_JDRV_BIT];
            pend_nxt      = '{soft_pin: ext_soft, jtag: i_jtag_reset_cmd, default: 1'b0};
          end
        end
        rst_seq_pkg::ST_PORD: begin
          cnt_nxt = cnt_r + 1'b1;
          if (cnt_r == CW'(POR_DLY_CYC - 1)) begin
            ph_nxt  = rst_seq_pkg::ST_LOCK;
            cnt_nxt = '0;
          end
        end
        rst_seq_pkg::ST_LOCK: begin
          cnt_nxt = cnt_r + 1'b1;
          if (cnt_r == lock_lim - 1'b1) begin
            ph_nxt   = rst_seq_pkg::ST_HREL;
            lock_nxt = 1'b1;
            cnt_nxt  = '0;
          end
        end
        rst_seq_pkg::ST_HREL: begin
          cnt_nxt = cnt_r + 1'b1;
          if (cnt_r == CW'(HRST_CYC - 1)) begin
            hdrv_nxt = 1'b0;
            ph_nxt   = rst_seq_pkg::ST_SREL;
          end
        end
        rst_seq_pkg::ST_SREL: begin
          cnt_nxt = cnt_r + 1'b1;
          if (cnt_r == CW'(SRST_CYC - 1)) begin
            sdrv_nxt = 1'b0;
            ph_nxt   = rst_seq_pkg::ST_IDLE;
            stat_nxt = pend_r;
            if (!cfg_wr_r && ctrl_r[`RS_CTRL_CMODE_BIT]) cfg_nxt = `RS_CFG_DEFAULT;
          end
        end
        rst_seq_pkg::ST_SOFT: begin
          cnt_nxt = cnt_r + 1'b1;
          if (cnt_r == CW'(SRST_CYC - HRST_CYC - 1)) begin
            sdrv_nxt = 1'b0;
            ph_nxt   = rst_seq_pkg::ST_IDLE;
            stat_nxt = pend_r;
          end
        end
        default: ph_nxt = rst_seq_pkg::ST_IDLE;
      endcase
      // slave-port config write only during power-on flow
      if (i_dsi_cfg_wr && (ph_r == rst_seq_pkg::ST_PORD || ph_r == rst_seq_pkg::ST_LOCK)) begin
        cfg_nxt    = i_dsi_cfg_data;
        cfg_wr_nxt = 1'b1;
      end else if (do_wr && awa_r == 8'(`RS_OFF_CFGWORD) && cfg_wr_ok) begin
        cfg_nxt    = wd_r;
        cfg_wr_nxt = 1'b1;
      end
    end
    if (hdrv_nxt) sdrv_nxt = 1'b1;
  end

  always_comb begin
    act_nxt.pll    = (ph_nxt == rst_seq_pkg::ST_PORD);
    act_nxt.system_interface_unit    = hard_flow_nxt && (ph_nxt != rst_seq_pkg::ST_IDLE);
    act_nxt.periph = (ph_nxt != rst_seq_pkg::ST_IDLE);
    act_nxt.core   = (ph_nxt != rst_seq_pkg::ST_IDLE);
    act_nxt.bus    = (ph_nxt != rst_seq_pkg::ST_IDLE);
  end

  // AXI4-Lite: take address and data in either order, answer one cycle later
  always_comb begin
    aw_nxt   = aw_r;
    w_nxt    = w_r;
    awa_nxt  = awa_r;
    wd_nxt   = wd_r;
    bv_nxt   = bv_r;
    br_nxt   = br_r;
    rv_nxt   = rv_r;
    rd_nxt   = rd_r;
    rr_nxt   = rr_r;
    ctrl_nxt = ctrl_r;
    if (i_awvalid && !aw_r && !bv_r) begin
      aw_nxt  = 1'b1;
      awa_nxt = i_awaddr;
    end
    if (i_wvalid && !w_r && !bv_r) begin
      w_nxt  = 1'b1;
      wd_nxt = i_wdata;
    end
    if (do_wr) begin
      aw_nxt = 1'b0;
      w_nxt  = 1'b0;
      bv_nxt = 1'b1;
      br_nxt = `RS_RESP_OKAY;
      case (awa_r)
        8'(`RS_OFF_CTRL):    if (i_wstrb[0]) ctrl_nxt = wd_r[2:0];
        8'(`RS_OFF_CFGWORD): if (!cfg_wr_ok) br_nxt = `RS_RESP_SLVERR;
        8'(`RS_OFF_STATUS), 8'(`RS_OFF_CFG), 8'(`RS_OFF_PHASE): br_nxt = `RS_RESP_OKAY;
        default:             br_nxt = `RS_RESP_SLVERR;
      endcase
    end else if (bv_r && i_bready) begin
      bv_nxt = 1'b0;
    end
    if (i_arvalid && !rv_r) begin
      rv_nxt = 1'b1;
      rr_nxt = `RS_RESP_OKAY;
      case (i_araddr)
        8'(`RS_OFF_CTRL):    rd_nxt = {29'h0, ctrl_r};
        8'(`RS_OFF_STATUS):  rd_nxt = {26'h0, stat_r};
        8'(`RS_OFF_CFG):     rd_nxt = {18'h0, strap_r};
        8'(`RS_OFF_CFGWORD): rd_nxt = cfg_r;
        8'(`RS_OFF_PHASE):   rd_nxt = {25'h0, !hpin_r, !spin_r, lock_r, cfg_wr_r, ph_r};
        default: begin
          rd_nxt = 32'h0000_0000;
          rr_nxt = `RS_RESP_SLVERR;
        end
      endcase
    end else if (rv_r && i_rready) begin
      rv_nxt = 1'b0;
    end
    // Self-reset pulse clears itself after one cycle; no reset flow reads it
    if (ctrl_r[`RS_CTRL_SSRST_BIT]) ctrl_nxt[`RS_CTRL_SSRST_BIT] = 1'b0;
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      ph_r        <= rst_seq_pkg::ST_PORD;
      cnt_r       <= '0;
      por_seen_r  <= 1'b1;
      hard_flow_r <= 1'b1;
      hdrv_r      <= 1'b1;
      sdrv_r      <= 1'b1;
      stat_r      <= '0;
      pend_r      <= '{por: 1'b1, default: 1'b0};
      strap_r     <= '0;
      act_r       <= '1;
      lock_r      <= 1'b0;
      cfg_r       <= `RS_CFG_DEFAULT;
      cfg_wr_r    <= 1'b0;
      ctrl_r      <= 3'h0;
      aw_r        <= 1'b0;
      w_r         <= 1'b0;
      awa_r       <= 8'h00;
      wd_r        <= 32'h0000_0000;
      bv_r        <= 1'b0;
      br_r        <= 2'h0;
      rv_r        <= 1'b0;
      rd_r        <= 32'h0000_0000;
      rr_r        <= 2'h0;
    end else begin
      ph_r        <= ph_nxt;
      cnt_r       <= cnt_nxt;
      por_seen_r  <= por_seen_nxt;
      hard_flow_r <= hard_flow_nxt;
      hdrv_r      <= hdrv_nxt;
      sdrv_r      <= sdrv_nxt;
      stat_r      <= stat_nxt;
      pend_r      <= pend_nxt;
      strap_r     <= strap_nxt;
      act_r       <= act_nxt;
      lock_r      <= lock_nxt;
      cfg_r       <= cfg_nxt;
      cfg_wr_r    <= cfg_wr_nxt;
      ctrl_r      <= ctrl_nxt;
      aw_r        <= aw_nxt;
      w_r         <= w_nxt;
      awa_r       <= awa_nxt;
      wd_r        <= wd_nxt;
      bv_r        <= bv_nxt;
      br_r        <= br_nxt;
      rv_r        <= rv_nxt;
      rd_r        <= rd_nxt;
      rr_r        <= rr_nxt;
    end
  end

  // Open-drain: data always low, enable low means pulling
  assign o_hard_reset_n  = 1'b0;
  assign o_soft_reset_n  = 1'b0;
  assign o_hard_reset_oe = !hdrv_r;
  assign o_soft_reset_oe = !sdrv_r;
  assign o_rst_act       = act_r;
  assign o_pll_locked    = lock_r;
  assign o_straps        = strap_r;
  assign o_cfg_word      = cfg_r;
  assign o_awready       = !aw_r && !bv_r;
  assign o_wready        = !w_r && !bv_r;
  assign o_bvalid        = bv_r;
  assign o_bresp         = br_r;
  assign o_arready       = !rv_r;
  assign o_rvalid        = rv_r;
  assign o_rdata         = rd_r;
  assign o_rresp         = rr_r;
endmodule

// [reset_source_sequencer_bench.sv]
// Self-checking bench for the reset source sequencer
`timescale 1ns/1ps
`include "rst_seq_consts.svh"
module reset_source_sequencer_bench;
  logic                  i_clk_sys, i_nrst, i_power_on_reset_n, i_wdog_expired;
  logic                  i_busmon_expired, i_jtag_reset_cmd, i_hard_reset_n, i_soft_reset_n;
  logic                  o_hard_reset_n, o_hard_reset_oe, o_soft_reset_n, o_soft_reset_oe;
  logic                  i_dsi_cfg_wr, o_pll_locked, i_awvalid, o_awready, i_wvalid;
  logic                  o_wready, o_bvalid, i_bready, i_arvalid, o_arready, o_rvalid, i_rready;
  logic                  ext_hard, ext_soft, hard_seen, soft_seen;
  logic [1:0]            i_ref_division_factor, o_bresp, o_rresp, r;
  logic [3:0]            i_wstrb, wstrb_use;
  logic [4:0]            act_seen;
  logic [7:0]            i_awaddr, i_araddr;
  logic [31:0]           i_dsi_cfg_data, o_cfg_word, i_wdata, o_rdata, d, exp_cfg;
  rst_seq_pkg::strap_t   i_straps, o_straps;
  rst_seq_pkg::rst_act_t o_rst_act;
  int                    fail_count, comparisons;
  logic [5:0]            st_tab [6] = '{6'h08, 6'h04, 6'h10, 6'h02, 6'h01, 6'h01};
  reset_source_sequencer #(.POR_DLY_CYC(8), .LOCK_CYC(16), .HRST_CYC(8), .SRST_CYC(11)) uut (
    .i_clk_sys, .i_nrst, .i_power_on_reset_n, .i_wdog_expired, .i_busmon_expired,
    .i_jtag_reset_cmd, .i_ref_division_factor, .i_hard_reset_n, .o_hard_reset_n,
    .o_hard_reset_oe, .i_soft_reset_n, .o_soft_reset_n, .o_soft_reset_oe, .i_straps,
    .i_dsi_cfg_wr, .i_dsi_cfg_data, .o_rst_act, .o_pll_locked, .o_straps, .o_cfg_word,
    .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp,
    .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid,
    .i_rready
  );
  board_supervisor_model sup (
    .i_clk_sys, .i_hard_oe(o_hard_reset_oe), .i_soft_oe(o_soft_reset_oe),
    .i_ext_hard(ext_hard), .i_ext_soft(ext_soft), .o_por_n(i_power_on_reset_n),
    .o_hard_n(i_hard_reset_n), .o_soft_n(i_soft_reset_n), .o_straps(i_straps)
  );
  initial begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end
  // Settled values only: sample away from the launching edge
  always @(negedge i_clk_sys) begin
    hard_seen |= !o_hard_reset_oe;
    soft_seen |= !o_soft_reset_oe;
    act_seen |= o_rst_act;
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    int n = 0;
    @(posedge i_clk_sys);
    i_awaddr <= a;
    i_wdata <= v;
    i_wstrb <= wstrb_use;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    do begin
      @(posedge i_clk_sys);
      if (o_awready) i_awvalid <= 1'b0;
      if (o_wready) i_wvalid <= 1'b0;
      n++;
    end while (o_bvalid !== 1'b1 && n < 50);
    rs = o_bresp;
    i_bready <= 1'b0;
    if (n == 50) fail_count++;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n = 0;
    @(posedge i_clk_sys);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do begin
      @(posedge i_clk_sys);
      if (o_arready) i_arvalid <= 1'b0;
      n++;
    end while (o_rvalid !== 1'b1 && n < 50);
    v = o_rdata;
    rs = o_rresp;
    i_rready <= 1'b0;
    if (n == 50) fail_count++;
  endtask
  task automatic wait_idle();
    int n = 0;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while ({o_hard_reset_oe, o_soft_reset_oe, o_rst_act} !== 7'h60 && n < 300);
    if (n == 300) fail_count++;
  endtask
  task automatic summarize();
    $display("Counts: %0d compared, %0d mismatched", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge i_clk_sys);
    fail_count++;
    summarize();
  end
  initial begin
    i_nrst = 1'b0;
    {i_wdog_expired, i_busmon_expired, i_jtag_reset_cmd, ext_hard, ext_soft} = '0;
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_dsi_cfg_wr} = '0;
    {i_awaddr, i_araddr, i_wdata, i_wstrb, i_dsi_cfg_data} = '0;
    {hard_seen, soft_seen, act_seen} = '0;
    i_ref_division_factor = 2'h1;
    wstrb_use = 4'hF;
    fail_count = 0;
    comparisons = 0;
    repeat (6) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    sup.power_on(14'h2A5C);
    chk("act_por", o_rst_act, 5'h1F);
    wait_idle();
    chk("lock", o_pll_locked, 1'b1);
    chk("straps", o_straps, 14'h2A5C);
    chk("cfg_default", o_cfg_word, `RS_CFG_DEFAULT);
    axr(`RS_OFF_STATUS, d, r);
    chk("status_por", d, 32'h20);
    axr(8'h40, d, r);
    chk("unmapped_data", d, 32'h0);
    chk("unmapped_resp", {30'h0, r}, {30'h0, `RS_RESP_SLVERR});
    $display("test power_on done");
    exp_cfg = `RS_CFG_DEFAULT;
    for (int k = 0; k < 6; k++) begin
      axw(`RS_OFF_CTRL, (k == 5) ? 32'h5 : 32'h1, r);
      {hard_seen, soft_seen, act_seen} = '0;
      case (k)
        0: i_wdog_expired <= 1'b1;
        1: i_busmon_expired <= 1'b1;
        2: ext_hard <= 1'b1;
        3: ext_soft <= 1'b1;
        default: i_jtag_reset_cmd <= 1'b1;
      endcase
      repeat (2) @(posedge i_clk_sys);
      {i_wdog_expired, i_busmon_expired, i_jtag_reset_cmd, ext_hard} <= '0;
      // Outside soft pull while busy must not count
      ext_soft <= (k != 3);
      i_dsi_cfg_wr <= 1'b1;
      i_dsi_cfg_data <= 32'hBAD0_0000;
      axw(`RS_OFF_CFGWORD, 32'hC0DE_0000 + k, r);
      ext_soft <= 1'b0;
      i_dsi_cfg_wr <= 1'b0;
      if (k < 3) exp_cfg = 32'hC0DE_0000 + k;
      chk("cfg_resp", r, (k < 3) ? `RS_RESP_OKAY : `RS_RESP_SLVERR);
      wait_idle();
      chk("cfg_word", o_cfg_word, exp_cfg);
      chk("actions", act_seen, (k < 3) ? 5'h0F : 5'h07);
      chk("hard_drive", hard_seen, k < 3);
      chk("soft_drive", soft_seen, k != 4);
      chk("straps_kept", o_straps, 14'h2A5C);
      axr(`RS_OFF_STATUS, d, r);
      chk("status", d, st_tab[k]);
      $display("test source %0d done", k);
    end
    i_ref_division_factor <= 2'h2;
    sup.power_on(14'h15A3);
    i_dsi_cfg_wr <= 1'b1;
    i_dsi_cfg_data <= 32'h0D51_0001;
    @(posedge i_clk_sys);
    i_dsi_cfg_wr <= 1'b0;
    wait_idle();
    chk("dsi_cfg", o_cfg_word, 32'h0D51_0001);
    chk("straps2", o_straps, 14'h15A3);
    axr(`RS_OFF_STATUS, d, r);
    chk("status_por2", d, 32'h20);
    $display("test second power_on done");
    // Low strobe byte clear: control must keep slave mode and soft drive
    wstrb_use = 4'hE;
    axw(`RS_OFF_CTRL, 32'h0, r);
    wstrb_use = 4'hF;
    axr(`RS_OFF_CTRL, d, r);
    chk("ctrl_strobe", d, 32'h5);
    // Slave mode, no word written: hard flow falls back to the default
    i_wdog_expired <= 1'b1;
    @(posedge i_clk_sys);
    i_wdog_expired <= 1'b0;
    wait_idle();
    chk("cfg_slave_default", o_cfg_word, `RS_CFG_DEFAULT);
    axr(`RS_OFF_STATUS, d, r);
    chk("status_wdog", d, 32'h08);
    $display("test slave default done");
    summarize();
  end
endmodule

// [reset_source_sequencer_checker.sv]
// Concurrent checks on the reset sequencer ports
`timescale 1ns/1ps
`include "rst_seq_consts.svh"
module reset_source_sequencer_checker #(
  parameter int unsigned HRST_CYC = `RS_HRST_CYC,
  parameter int unsigned SRST_CYC = `RS_SRST_CYC
) (
  // Clock and reset
  input wire logic                  i_clk_sys,
  input wire logic                  i_nrst,
  // Watched ports
  input wire logic                  i_power_on_reset_n,
  input wire logic                  o_hard_reset_n,
  input wire logic                  o_hard_reset_oe,
  input wire logic                  o_soft_reset_n,
  input wire logic                  o_soft_reset_oe,
  input wire rst_seq_pkg::rst_act_t o_rst_act,
  input wire logic                  o_pll_locked,
  input wire logic                  o_bvalid,
  input wire logic [1:0]            o_bresp
);
  // Exact release points; a loose window would hide an off-by-one count
  localparam int HREL_DLY = HRST_CYC - 5;
  localparam int SREL_DLY = SRST_CYC - HRST_CYC - 2;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  property p_pins_low;
    o_hard_reset_n == 1'b0 && o_soft_reset_n == 1'b0;
  endproperty
  a_pins_low: assert property (p_pins_low) else $error("reset pin drives high");
  property p_soft_with_hard;
    !o_hard_reset_oe |-> !o_soft_reset_oe;
  endproperty
  a_soft_with_hard: assert property (p_soft_with_hard) else $error("soft freed early");
  property p_por_pll;
    !i_power_on_reset_n |-> ##[0:2] (o_rst_act.pll && !o_hard_reset_oe && !o_soft_reset_oe);
  endproperty
  a_por_pll: assert property (p_por_pll) else $error("power-on actions missing");
  property p_lock_clear;
    $fell(i_power_on_reset_n) |-> ##[1:3] !o_pll_locked;
  endproperty
  a_lock_clear: assert property (p_lock_clear) else $error("lock kept on power-on");
  property p_no_early_lock;
    $rose(i_power_on_reset_n) |-> !o_pll_locked [*8];
  endproperty
  a_no_early_lock: assert property (p_no_early_lock) else $error("lock too early");
  property p_hard_rel;
    $rose(o_pll_locked) |-> !o_hard_reset_oe [*6] ##[HREL_DLY:HREL_DLY] o_hard_reset_oe;
  endproperty
  a_hard_rel: assert property (p_hard_rel) else $error("hard pin release time");
  property p_soft_rel;
    $rose(o_hard_reset_oe) |-> !o_soft_reset_oe [*3] ##[SREL_DLY:SREL_DLY] o_soft_reset_oe;
  endproperty
  a_soft_rel: assert property (p_soft_rel) else $error("soft pin release time");
  property p_siu_hard;
    $rose(o_rst_act.system_interface_unit) |-> ##[0:2] !o_hard_reset_oe;
  endproperty
  a_siu_hard: assert property (p_siu_hard) else $error("siu reset without hard");
  property p_core_all;
    o_rst_act.core |-> o_rst_act.periph && o_rst_act.bus;
  endproperty
  a_core_all: assert property (p_core_all) else $error("partial reset");
  c_hard_rel: cover property ($rose(o_hard_reset_oe));
  c_soft_rel: cover property ($rose(o_soft_reset_oe));
  c_slverr: cover property (o_bvalid && o_bresp == `RS_RESP_SLVERR);
endmodule
bind reset_source_sequencer reset_source_sequencer_checker #(
  .HRST_CYC(HRST_CYC),
  .SRST_CYC(SRST_CYC)
) chk_i (
  .i_clk_sys, .i_nrst, .i_power_on_reset_n, .o_hard_reset_n, .o_hard_reset_oe,
  .o_soft_reset_n, .o_soft_reset_oe, .o_rst_act, .o_pll_locked, .o_bvalid, .o_bresp
);

// [rst_seq_consts.svh]
// Constants for the reset source sequencer
`ifndef RST_SEQ_CONSTS_SVH
`define RST_SEQ_CONSTS_SVH
`define RS_OFF_CTRL       32'h0000_0000
`define RS_OFF_STATUS     32'h0000_0004
`define RS_OFF_CFG        32'h0000_0008
`define RS_OFF_CFGWORD    32'h0000_000C
`define RS_OFF_PHASE      32'h0000_0010
`define RS_POR_DLY_CYC    1024
`define RS_LOCK_CYC       6400
`define RS_HRST_CYC       512
`define RS_SRST_CYC       515
`define RS_POR_MIN_CYC    16
`define RS_CFG_DEFAULT    32'h0000_0000
`define RS_CTRL_CMODE_BIT 0
`define RS_CTRL_SSRST_BIT 1
`define RS_CTRL_JDRV_BIT  2
`define RS_RESP_OKAY      2'b00
`define RS_RESP_SLVERR    2'b10
`endif

// [rst_seq_pkg.sv]
// Types for the reset source sequencer
package rst_seq_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_PORD  = 3'b001,
    ST_LOCK  = 3'b010,
    ST_HREL  = 3'b011,
    ST_SREL  = 3'b100,
    ST_SOFT  = 3'b101
  } phase_t;
  typedef struct packed {
    logic       cfg_select;
    logic       cfg_source;
    logic       slave_sync;
    logic       slave_wide;
    logic [3:0] chip_identifier_pins;
    logic [2:0] boot_mode;
    logic       wdog_en;
    logic [1:0] clk_mode;
  } strap_t;
  typedef struct packed {
    logic por;
    logic hard_pin;
    logic wdog;
    logic busmon;
    logic soft_pin;
    logic jtag;
  } src_t;
  typedef struct packed {
    logic pll;
    logic system_interface_unit;
    logic periph;
    logic core;
    logic bus;
  } rst_act_t;
endpackage
